// [logic/mcc_pkg.sv]
// Purpose: Shared constants and types for the line coherence state block.
// Assumes: A small directory of lines, each core holding a private state per line.
// Notes: State codes are one-hot so an illegal code is easy to spot.
package mcc_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int MCC_CORES = 4;
  localparam int MCC_LINES = 8;
  localparam int MCC_IDX_W = 3;
  localparam int MCC_CORE_W = 2;
  localparam int MCC_DATA_W = 32;

  // ----------------------------------------------------------------
  // Line states and request kinds
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MCC_INVALID = 5'h01,
    MCC_SHARED = 5'h02,
    MCC_EXCLUSIVE = 5'h04,
    MCC_OWNED = 5'h08,
    MCC_MODIFIED = 5'h10
  } mcc_state_t;

  typedef enum logic [1:0] {
    MCC_REQ_READ = 2'h0,
    MCC_REQ_WRITE = 2'h1,
    MCC_REQ_WIPF = 2'h2,
    MCC_REQ_EVICT = 2'h3
  } mcc_req_t;
endpackage

// [logic/mcc_coherence.sv]
// Purpose: Coherence state keeper for lines between private core caches and a shared cache.
// Assumes: One request per cycle; the memory controller finishes probes and fills.
// Notes: Each core slot stands for its private first and second level caches.
module mcc_coherence import mcc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Request from a core.
  input wire logic req_valid,
  input wire mcc_req_t req_kind,
  input wire logic [MCC_CORE_W-1:0] req_core,
  input wire logic [MCC_IDX_W-1:0] req_line,
  output logic req_ready,
  // Answer to the core.
  output logic rsp_valid,
  output logic rsp_hit,
  output mcc_state_t rsp_state,
  // Memory controller side.
  output logic mc_req,
  output logic mc_probe,
  output logic mc_writeback,
  output logic [MCC_IDX_W-1:0] mc_line,
  input wire logic mc_done
);
  // ----------------------------------------------------------------
  // State storage
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MCC_IDLE = 2'h1,
    MCC_WAIT = 2'h2
  } mcc_fsm_t;

  mcc_state_t priv [MCC_CORES][MCC_LINES], next_priv [MCC_CORES][MCC_LINES];
  mcc_state_t l3 [MCC_LINES], next_l3 [MCC_LINES];
  mcc_fsm_t fsm, next_fsm;
  mcc_req_t wait_kind, next_wait_kind;
  logic [MCC_CORE_W-1:0] wait_core, next_wait_core;
  logic [MCC_IDX_W-1:0] wait_line, next_wait_line, next_mc_line;
  logic next_rsp_valid, next_rsp_hit, next_mc_req, next_mc_probe, next_mc_writeback;
  mcc_state_t next_rsp_state;

  // Tells whether any core other than the requester holds a live copy.
  function automatic logic others_hold(input mcc_state_t p [MCC_CORES][MCC_LINES],
                                       input logic [MCC_CORE_W-1:0] c,
                                       input logic [MCC_IDX_W-1:0] l);
    logic r = 1'b0;
    for (int i = 0; i < MCC_CORES; i++) begin
      if (i[MCC_CORE_W-1:0] != c && p[i][l] != MCC_INVALID) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  assign req_ready = (fsm == MCC_IDLE);
  // Current state of the requested line, used by the transitions and by the checks.
  mcc_state_t mine, sh;
  logic oth, take;
  assign mine = priv[req_core][req_line];
  assign sh = l3[req_line];
  assign oth = others_hold(priv, req_core, req_line);
  assign take = ce && req_valid && req_ready;

  // ----------------------------------------------------------------
  // Transition logic
  // ----------------------------------------------------------------
  // Computes the whole next state of one line in a single step.
  always_comb begin
    next_priv = priv;
    next_l3 = l3;
    next_fsm = fsm;
    next_wait_kind = wait_kind;
    next_wait_core = wait_core;
    next_wait_line = wait_line;
    next_rsp_valid = 1'b0;
    next_rsp_hit = 1'b0;
    next_rsp_state = MCC_INVALID;
    next_mc_req = 1'b0;
    next_mc_probe = 1'b0;
    next_mc_writeback = 1'b0;
    next_mc_line = mc_line;
    unique case (fsm)
      MCC_IDLE: begin
        if (req_valid) begin
          next_rsp_valid = 1'b1;
          next_mc_line = req_line;
          unique case (req_kind)
            MCC_REQ_READ: begin
              if (mine != MCC_INVALID) begin
                next_rsp_hit = 1'b1;
                next_rsp_state = mine;
              end else if (sh != MCC_INVALID) begin
                if (sh == MCC_MODIFIED || sh == MCC_OWNED) begin
                  next_l3[req_line] = MCC_OWNED;
                end
                next_priv[req_core][req_line] = MCC_SHARED;
                next_rsp_hit = 1'b1;
                next_rsp_state = MCC_SHARED;
              end else begin
                // Miss: ask memory, then fill exclusive or shared.
                next_rsp_valid = 1'b0;
                next_mc_req = 1'b1;
                next_fsm = MCC_WAIT;
              end
            end
            MCC_REQ_WRITE: begin
              if (mine == MCC_MODIFIED || mine == MCC_EXCLUSIVE) begin
                next_priv[req_core][req_line] = MCC_MODIFIED;
                next_rsp_hit = 1'b1;
                next_rsp_state = MCC_MODIFIED;
              end else if (sh == MCC_MODIFIED && !oth) begin
                next_l3[req_line] = MCC_INVALID;
                next_priv[req_core][req_line] = MCC_MODIFIED;
                next_rsp_hit = 1'b1;
                next_rsp_state = MCC_MODIFIED;
              end else begin
                next_rsp_valid = 1'b0;
                next_mc_probe = (sh == MCC_OWNED) || (mine != MCC_INVALID) || oth;
                next_mc_req = !next_mc_probe;
                next_fsm = MCC_WAIT;
              end
            end
            MCC_REQ_WIPF: begin
              if (mine == MCC_MODIFIED) begin
                next_rsp_hit = 1'b1;
                next_rsp_state = MCC_MODIFIED;
              end else if (sh == MCC_MODIFIED && !oth) begin
                next_l3[req_line] = MCC_INVALID;
                next_priv[req_core][req_line] = MCC_MODIFIED;
                next_rsp_hit = 1'b1;
                next_rsp_state = MCC_MODIFIED;
              end else begin
                next_rsp_valid = 1'b0;
                next_mc_probe = (sh != MCC_INVALID) || oth;
                next_mc_req = !((sh != MCC_INVALID) || oth);
                next_fsm = MCC_WAIT;
              end
            end
            MCC_REQ_EVICT: begin
              // Victims climb into the shared cache; it has no other fill path.
              next_priv[req_core][req_line] = MCC_INVALID;
              next_rsp_state = MCC_INVALID;
              if (mine == MCC_MODIFIED || mine == MCC_OWNED) begin
                next_l3[req_line] = mine;
                next_mc_writeback = (sh == MCC_OWNED);
              end else if (mine == MCC_EXCLUSIVE && sh == MCC_INVALID) begin
                next_l3[req_line] = MCC_EXCLUSIVE;
              end else if (mine == MCC_SHARED && sh == MCC_INVALID) begin
                next_l3[req_line] = MCC_SHARED;
              end
            end
          endcase
          next_wait_kind = req_kind;
          next_wait_core = req_core;
          next_wait_line = req_line;
        end
      end
      MCC_WAIT: begin
        if (mc_done) begin
          // Probes and fills done: every other copy is gone for a write.
          next_fsm = MCC_IDLE;
          next_rsp_valid = 1'b1;
          if (wait_kind == MCC_REQ_READ) begin
            for (int i = 0; i < MCC_CORES; i++) begin
              if (priv[i][wait_line] == MCC_EXCLUSIVE) begin
                next_priv[i][wait_line] = MCC_SHARED;
              end
            end
            if (others_hold(priv, wait_core, wait_line)) begin
              next_priv[wait_core][wait_line] = MCC_SHARED;
              next_rsp_state = MCC_SHARED;
            end else begin
              next_priv[wait_core][wait_line] = MCC_EXCLUSIVE;
              next_rsp_state = MCC_EXCLUSIVE;
            end
          end else begin
            for (int i = 0; i < MCC_CORES; i++) begin
              next_priv[i][wait_line] = MCC_INVALID;
            end
            next_l3[wait_line] = MCC_INVALID;
            next_priv[wait_core][wait_line] = MCC_MODIFIED;
            next_rsp_state = MCC_MODIFIED;
          end
        end
      end
    endcase
  end

  // Registers every field of the transition together.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      priv <= '{default: MCC_INVALID};
      l3 <= '{default: MCC_INVALID};
      fsm <= MCC_IDLE;
      wait_kind <= MCC_REQ_READ;
      wait_core <= '0;
      wait_line <= '0;
      rsp_valid <= 1'b0;
      rsp_hit <= 1'b0;
      rsp_state <= MCC_INVALID;
      mc_req <= 1'b0;
      mc_probe <= 1'b0;
      mc_writeback <= 1'b0;
      mc_line <= '0;
    end else if (ce) begin
      priv <= next_priv;
      l3 <= next_l3;
      fsm <= next_fsm;
      wait_kind <= next_wait_kind;
      wait_core <= next_wait_core;
      wait_line <= next_wait_line;
      rsp_valid <= next_rsp_valid;
      rsp_hit <= next_rsp_hit;
      rsp_state <= next_rsp_state;
      mc_req <= next_mc_req;
      mc_probe <= next_mc_probe;
      mc_writeback <= next_mc_writeback;
      mc_line <= next_mc_line;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_write_owned_probes;
    @(posedge clk) disable iff (!nrst)
      (take && req_kind == MCC_REQ_WRITE && mine == MCC_INVALID && sh == MCC_OWNED)
      |=> mc_probe && !rsp_valid;
  endproperty
  a_write_owned_probes: assert property (p_write_owned_probes)
    else $error("Write to owned line did not raise probes.");
  property p_write_mod_noprobe;
    @(posedge clk) disable iff (!nrst)
      (take && req_kind == MCC_REQ_WRITE && mine == MCC_INVALID && sh == MCC_MODIFIED && !oth)
      |=> rsp_valid && !mc_probe && rsp_state == MCC_MODIFIED;
  endproperty
  a_write_mod_noprobe: assert property (p_write_mod_noprobe)
    else $error("Write to modified shared line used probes.");
  property p_read_mod_owned;
    @(posedge clk) disable iff (!nrst)
      (take && req_kind == MCC_REQ_READ && mine == MCC_INVALID && sh == MCC_MODIFIED)
      |=> l3[$past(req_line)] == MCC_OWNED && rsp_state == MCC_SHARED;
  endproperty
  a_read_mod_owned: assert property (p_read_mod_owned)
    else $error("Read of modified line did not leave owned and shared.");
  property p_wipf_moves;
    @(posedge clk) disable iff (!nrst)
      (take && req_kind == MCC_REQ_WIPF && mine == MCC_INVALID && sh == MCC_MODIFIED && !oth)
      |=> l3[$past(req_line)] == MCC_INVALID && rsp_state == MCC_MODIFIED;
  endproperty
  a_wipf_moves: assert property (p_wipf_moves)
    else $error("Write-intent prefetch left a copy in the shared cache.");
  property p_evict_victim;
    @(posedge clk) disable iff (!nrst)
      (take && req_kind == MCC_REQ_EVICT && mine == MCC_MODIFIED)
      |=> l3[$past(req_line)] == MCC_MODIFIED;
  endproperty
  a_evict_victim: assert property (p_evict_victim)
    else $error("Evicted modified line did not reach the shared cache.");
  property p_miss_asks;
    @(posedge clk) disable iff (!nrst)
      (take && req_kind == MCC_REQ_READ && mine == MCC_INVALID && sh == MCC_INVALID)
      |=> mc_req && !req_ready;
  endproperty
  a_miss_asks: assert property (p_miss_asks)
    else $error("Miss did not ask the memory controller.");
  property p_fill_modified;
    @(posedge clk) disable iff (!nrst)
      (ce && fsm == MCC_WAIT && mc_done && wait_kind == MCC_REQ_WRITE)
      |=> rsp_valid && rsp_state == MCC_MODIFIED && l3[$past(wait_line)] == MCC_INVALID;
  endproperty
  a_fill_modified: assert property (p_fill_modified)
    else $error("Write fill did not end in modified.");
  property p_read_no_fill_l3;
    @(posedge clk) disable iff (!nrst)
      (ce && fsm == MCC_WAIT && mc_done && wait_kind == MCC_REQ_READ)
      |=> l3[$past(wait_line)] == $past(l3[wait_line]);
  endproperty
  a_read_no_fill_l3: assert property (p_read_no_fill_l3)
    else $error("Shared cache filled by a private fill.");
endmodule

// [testbench/mcc_mem_model.sv]
// Purpose: Behavioural memory controller that answers fetch and probe pulses of the block.
// Assumes: One outstanding fetch or probe at a time, as the block allows.
// Notes: The bench picks the latency, so answers can be prompt or slow.
module mcc_mem_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Requests from the block.
  input wire logic mc_req,
  input wire logic mc_probe,
  // Extra answer delay in cycles.
  input wire logic [3:0] lat,
  // Completion pulse back to the block.
  output logic mc_done
);
  timeunit 1ns;
  timeprecision 1ns;

  logic busy;
  logic [3:0] cnt;

  // Finish a fetch or a probe round after the chosen delay, one cycle wide.
  always @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      cnt <= 4'h0;
      mc_done <= 1'b0;
    end else begin
      mc_done <= 1'b0;
      if (busy) begin
        if (cnt == 4'h0) begin
          mc_done <= 1'b1;
          busy <= 1'b0;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end else if (mc_req || mc_probe) begin
        busy <= 1'b1;
        cnt <= lat;
      end
    end
  end
endmodule

// [testbench/mcc_coherence_tb.sv]
// Purpose: Self-checking bench for the line coherence state block.
// Assumes: Inputs change at the falling edge; the memory controller is modelled.
// Notes: Scenarios follow lines 0, 1 and 2 through producer and consumer cores.
`define CHK(nm, e, g) begin \
  total_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("BAD %s expected %h seen %h", nm, e, g); \
  end \
end
module mcc_coherence_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mcc_pkg::*;

  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  mcc_req_t req_kind = MCC_REQ_READ;
  logic [MCC_CORE_W-1:0] req_core = '0;
  logic [MCC_IDX_W-1:0] req_line = '0;
  logic req_ready, rsp_valid, rsp_hit, mc_req, mc_probe, mc_writeback, mc_done;
  mcc_state_t rsp_state;
  logic [MCC_IDX_W-1:0] mc_line;
  logic [3:0] lat = 4'h0;
  logic got_hit, saw_req, saw_probe, saw_wb;
  mcc_state_t got_state;
  int failures = 0;
  int total_checks = 0;

  mcc_coherence dut_u (.clk(clk), .nrst(nrst), .ce(ce), .req_valid(req_valid),
    .req_kind(req_kind), .req_core(req_core), .req_line(req_line), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_state(rsp_state), .mc_req(mc_req),
    .mc_probe(mc_probe), .mc_writeback(mc_writeback), .mc_line(mc_line), .mc_done(mc_done));

  mcc_mem_model mem_u (.clk(clk), .nrst(nrst), .mc_req(mc_req), .mc_probe(mc_probe),
    .lat(lat), .mc_done(mc_done));

  // Free-running 25 MHz clock.
  always #20 clk = ~clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Print the counts and the verdict, then end the run.
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Issue one request, wait for its answer and note any memory traffic.
  task automatic do_req(input mcc_req_t k, input logic [1:0] c, input logic [2:0] l);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    saw_req = 1'b0;
    saw_probe = 1'b0;
    saw_wb = 1'b0;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind = k;
    req_core = c;
    req_line = l;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (!got && n < 50) begin
      saw_req = saw_req | (mc_req === 1'b1);
      saw_probe = saw_probe | (mc_probe === 1'b1);
      saw_wb = saw_wb | (mc_writeback === 1'b1);
      if (rsp_valid === 1'b1) begin
        got = 1'b1;
        got_hit = rsp_hit;
        got_state = rsp_state;
      end else begin
        @(negedge clk);
        n++;
      end
    end
    if (!got) begin
      failures++;
      $display("BAD answer expected 1 seen timeout");
      stop_test();
    end
    `CHK("mc_line", l, mc_line)
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Idle after reset: ready and nothing held.
  task automatic t_reset;
    `CHK("req_ready", 1'b1, req_ready)
    `CHK("rsp_state", MCC_INVALID, rsp_state)
    `CHK("reset mc_req", 1'b0, mc_req)
    `CHK("reset mc_writeback", 1'b0, mc_writeback)
  endtask

  // Clock enable low freezes a pending request.
  task automatic t_freeze;
    @(negedge clk);
    ce = 1'b0;
    req_valid = 1'b1;
    req_line = 3'h3;
    repeat (3) begin
      @(negedge clk);
      `CHK("frozen rsp_valid", 1'b0, rsp_valid)
      `CHK("frozen mc_req", 1'b0, mc_req)
    end
    req_valid = 1'b0;
    ce = 1'b1;
  endtask

  // Slow fill of an empty line, then a second reader on another core.
  task automatic t_read_miss;
    lat = 4'h5;
    do_req(MCC_REQ_READ, 2'h0, 3'h0);
    `CHK("miss fetch", 1'b1, saw_req)
    `CHK("miss hit", 1'b0, got_hit)
    `CHK("first reader", MCC_EXCLUSIVE, got_state)
    lat = 4'h0;
    do_req(MCC_REQ_READ, 2'h1, 3'h0);
    `CHK("second reader", MCC_SHARED, got_state)
    do_req(MCC_REQ_READ, 2'h0, 3'h0);
    `CHK("first reader after share", MCC_SHARED, got_state)
    `CHK("first reader hit", 1'b1, got_hit)
    do_req(MCC_REQ_READ, 2'h3, 3'h2);
    `CHK("excl fill", MCC_EXCLUSIVE, got_state)
    do_req(MCC_REQ_WRITE, 2'h3, 3'h2);
    `CHK("excl store", MCC_MODIFIED, got_state)
    `CHK("excl store traffic", 1'b0, saw_req | saw_probe)
  endtask

  // Producer allocates, spills the victim, consumer reads it from the shared cache.
  task automatic t_producer_consumer;
    do_req(MCC_REQ_WRITE, 2'h0, 3'h1);
    `CHK("store alloc", MCC_MODIFIED, got_state)
    do_req(MCC_REQ_EVICT, 2'h0, 3'h1);
    `CHK("evicted", MCC_INVALID, got_state)
    `CHK("evict writeback", 1'b0, saw_wb)
    do_req(MCC_REQ_READ, 2'h1, 3'h1);
    `CHK("consumer state", MCC_SHARED, got_state)
    `CHK("consumer hit", 1'b1, got_hit)
    `CHK("consumer fetch", 1'b0, saw_req)
    lat = 4'h3;
    do_req(MCC_REQ_WRITE, 2'h0, 3'h1);
    `CHK("owned probe", 1'b1, saw_probe)
    `CHK("owned hit", 1'b0, got_hit)
    `CHK("owned done", MCC_MODIFIED, got_state)
    lat = 4'h0;
  endtask

  // Write on a modified shared-cache line, then a write-intent prefetch.
  task automatic t_modified_paths;
    do_req(MCC_REQ_EVICT, 2'h0, 3'h1);
    do_req(MCC_REQ_WRITE, 2'h2, 3'h1);
    `CHK("mod probe", 1'b0, saw_probe)
    `CHK("mod hit", 1'b1, got_hit)
    `CHK("mod state", MCC_MODIFIED, got_state)
    do_req(MCC_REQ_EVICT, 2'h2, 3'h1);
    do_req(MCC_REQ_WIPF, 2'h3, 3'h1);
    `CHK("wipf state", MCC_MODIFIED, got_state)
    `CHK("wipf probe", 1'b0, saw_probe)
    do_req(MCC_REQ_WRITE, 2'h2, 3'h1);
    `CHK("gone hit", 1'b0, got_hit)
    `CHK("gone traffic", 1'b1, saw_req | saw_probe)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    t_reset();
    t_freeze();
    t_read_miss();
    t_producer_consumer();
    t_modified_paths();
    stop_test();
  end
endmodule
